// [core/psp_params.svh]
// Constants for the serial synthesizer programming link.
// Included by the package and both ends; definitions only.
`ifndef PSP_PARAMS_SVH
`define PSP_PARAMS_SVH
`define PSP_WORD_BITS 24
`define PSP_BYTE_BITS 8
`define PSP_SEL_REF 2'h0
`define PSP_SEL_AB 2'h1
`define PSP_SEL_FUNC 2'h2
`define PSP_SEL_INIT 2'h3
`define PSP_CNT_RST_POS 2
`define PSP_SCLK_MAX_MHZ 20
`define PSP_PCLK_MHZ 100
`define PSP_SCLK_DIV (2 * `PSP_SCLK_MAX_MHZ)
`define PSP_SCLK_HALF ((`PSP_PCLK_MHZ + `PSP_SCLK_DIV - 1) / `PSP_SCLK_DIV)
`define PSP_SETTLE_NS 1000
`define PSP_SETTLE_CYC ((`PSP_SETTLE_NS * `PSP_PCLK_MHZ) / 1000)
`define PSP_REG_CMD 12'h000
`define PSP_REG_WORD 12'h004
`define PSP_REG_STAT 12'h008
`define PSP_REG_FUNC 12'h00c
`define PSP_REG_REF 12'h010
`define PSP_REG_AB 12'h014
`define PSP_REG_CTRL 12'h018
`endif

// [core/psp_pkg.sv]
// Types shared by both ends of the programming link.
// Assumes psp_params.svh on the include path.
`include "psp_params.svh"
package psp_pkg;
    typedef logic [`PSP_WORD_BITS-1:0] psp_word_t;
    typedef enum logic [1:0] {
        PSP_LATCH_REF, PSP_LATCH_AB, PSP_LATCH_FUNC, PSP_LATCH_INIT
    } psp_latch_t;
endpackage

// [core/psp_link_if.sv]
// Three-wire write-only link between host and synthesizer control.
// Host drives all three lines and power enable; device returns only the test output.
interface psp_link_if;
    logic sclk;
    logic sdata;
    logic latch_load_strobe;
    logic power_enable;
    logic test_output_pin;
    modport host (output sclk, output sdata, output latch_load_strobe,
        output power_enable, input test_output_pin);
    modport device (input sclk, input sdata, input latch_load_strobe,
        input power_enable, output test_output_pin);
endinterface

// [core/psp_device.sv]
// Device end: serial input register, three latches, power and reset state.
// Assumes link pins are asynchronous to pclk; samples them twice.
//
// Operation
// - Enable low forces immediate power-down.
// - Enable-gated start: load latches, then enable.
// - Host waits about 1 us after enable.
// - Latches keep contents across enable cycles.
// - Counter-reset start: set, load, clear bit.
// - Counter reset holds counters, no power-down.
// - Shift on rising clock; strobe latches 24.
// - Low two bits select destination latch.
// - Serial clock at most 20 MHz.
// - Strobe low, three bytes, then strobe high.
// - SPI phase zero, data before rising edge.
// - Four writes after supply before output.
// - Host may poll test output for lock.
// - Select 11 loads init, pulses reset.
// - Input register works during power-down.
// - Data bit 2 of function is counter reset.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`include "psp_params.svh"
module psp_device
    import psp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    psp_link_if.device link,
    output logic [`PSP_WORD_BITS-1:0] func_latch,
    output logic [`PSP_WORD_BITS-1:0] ref_latch,
    output logic [`PSP_WORD_BITS-1:0] ab_latch,
    output logic powered_down,
    output logic counters_held,
    output logic pump_tristate,
    output logic reset_pulse,
    input wire logic lock_status
);
    localparam int NPIN = 4;
    localparam int PIN_SCLK = 0;
    localparam int PIN_SDATA = 1;
    localparam int PIN_STROBE = 2;
    localparam int PIN_EN = 3;

    wire [NPIN-1:0] pin_raw;
    wire [NPIN-1:0] pin_sync;
    logic sclk_prev_q;
    logic strobe_prev_q;
    psp_word_t shift_q;
    psp_word_t shift_d;
    psp_word_t func_q;
    psp_word_t func_d;
    psp_word_t ref_q;
    psp_word_t ref_d;
    psp_word_t ab_q;
    psp_word_t ab_d;
    logic init_armed_q;
    logic init_armed_d;
    logic pd_q;
    logic pd_d;
    logic held_q;
    logic held_d;
    logic tri_q;
    logic tri_d;
    logic pulse_q;
    logic pulse_d;
    logic test_q;
    logic test_d;

    assign pin_raw[PIN_SCLK] = link.sclk;
    assign pin_raw[PIN_SDATA] = link.sdata;
    assign pin_raw[PIN_STROBE] = link.latch_load_strobe;
    assign pin_raw[PIN_EN] = link.power_enable;

    // Every pin is asynchronous; only the second stage feeds logic,
    // so clock and data keep the same latency through the stages
    for (genvar g = 0; g < NPIN; g++) begin : g_sync
        logic meta_q;
        logic sync_q;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_q <= 1'b0;
                sync_q <= 1'b0;
            end else begin
                meta_q <= pin_raw[g];
                sync_q <= meta_q;
            end
        end
        assign pin_sync[g] = sync_q;
    end

    wire sclk_s = pin_sync[PIN_SCLK];
    wire sdata_s = pin_sync[PIN_SDATA];
    wire strobe_s = pin_sync[PIN_STROBE];
    wire enabled = pin_sync[PIN_EN];

    // Edge memories reset to the low level both pins are driven to in reset
    wire sclk_rise = sclk_s & ~sclk_prev_q;
    wire strobe_rise = strobe_s & ~strobe_prev_q;

    // Select bits arrive last, so they sit at the bottom
    wire [1:0] sel = shift_q[1:0];
    psp_latch_t dest;
    assign dest = psp_latch_t'(sel);
    wire is_init = strobe_rise && dest == PSP_LATCH_INIT;
    wire is_func = strobe_rise && dest == PSP_LATCH_FUNC;
    wire load_func = is_func || is_init;
    wire load_ref = strobe_rise && dest == PSP_LATCH_REF;
    wire load_ab = strobe_rise && dest == PSP_LATCH_AB;
    // Init word and the first AB load after it both pulse reset
    wire fire_pulse = is_init || (load_ab && init_armed_q);
    wire cnt_rst = func_q[`PSP_CNT_RST_POS];
    // Counter reset and pulse hold counters but never power down
    wire hold_cnt = ~enabled | cnt_rst | fire_pulse;

    // Shifting ignores power state entirely
    assign shift_d = sclk_rise ?
        {shift_q[`PSP_WORD_BITS-2:0], sdata_s} : shift_q;
    assign func_d = load_func ? shift_q : func_q;
    assign ref_d = load_ref ? shift_q : ref_q;
    assign ab_d = load_ab ? shift_q : ab_q;
    // Only a later init word re-arms the pulse
    assign init_armed_d = is_init ? 1'b1 : (load_ab ? 1'b0 : init_armed_q);
    assign pd_d = ~enabled;
    assign held_d = hold_cnt;
    assign tri_d = hold_cnt;
    assign pulse_d = fire_pulse;
    assign test_d = lock_status & enabled;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev_q <= 1'b0;
            strobe_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            strobe_prev_q <= strobe_s;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            shift_q <= '0;
        else
            shift_q <= shift_d;
    end

    // Latches are reset only by presetn (supply), never by enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_q <= '0;
            ref_q <= '0;
            ab_q <= '0;
        end else begin
            func_q <= func_d;
            ref_q <= ref_d;
            ab_q <= ab_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            init_armed_q <= 1'b0;
        else
            init_armed_q <= init_armed_d;
    end

    // Power-down starts asserted until enable is seen high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pd_q <= 1'b1;
        else
            pd_q <= pd_d;
    end

    // Hold and three-state share one condition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_q <= 1'b1;
            tri_q <= 1'b1;
        end else begin
            held_q <= held_d;
            tri_q <= tri_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pulse_q <= 1'b0;
        else
            pulse_q <= pulse_d;
    end

    // Gated so a disabled part never shows lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            test_q <= 1'b0;
        else
            test_q <= test_d;
    end

    assign link.test_output_pin = test_q;
    assign func_latch = func_q;
    assign ref_latch = ref_q;
    assign ab_latch = ab_q;
    assign powered_down = pd_q;
    assign counters_held = held_q;
    assign pump_tristate = tri_q;
    assign reset_pulse = pulse_q;
endmodule

// [core/psp_host.sv]
// Host end: APB slave registers and a 24-bit serial writer.
// Assumes pclk at 100 MHz; link clock made here by a divider.
`include "psp_params.svh"
module psp_host
    import psp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    psp_link_if.host link
);
    localparam int HALF = `PSP_SCLK_HALF;
    typedef enum logic [1:0] {PSP_IDLE, PSP_LOW, PSP_HIGH, PSP_END} psp_st_t;
    psp_st_t st_q;
    psp_word_t word_q, shreg_q;
    logic [4:0] bits_q;
    logic [7:0] div_q;
    logic sclk_q, sdata_q, strobe_q, en_q;
    logic [1:0] lock_s_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;

    wire acc = psel & penable & ~pready_q;
    // Writes land only at the edge that completes the transfer
    wire done = psel & penable & pready_q;
    wire wr = done & pwrite;
    wire hit_cmd = paddr == `PSP_REG_CMD;
    wire hit_word = paddr == `PSP_REG_WORD;
    wire hit_stat = paddr == `PSP_REG_STAT;
    wire hit_ctrl = paddr == `PSP_REG_CTRL;
    wire mapped = hit_cmd | hit_word | hit_stat | hit_ctrl;
    wire busy = st_q != PSP_IDLE;
    wire go = wr & hit_cmd & pwdata[0] & ~busy;
    wire tick = div_q == 8'(HALF - 1);
    wire [31:0] rd_mux = hit_word ? {8'h00, word_q} :
        hit_stat ? {29'h0, lock_s_q[1], en_q, busy} :
        hit_ctrl ? {31'h0, en_q} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
            word_q <= '0;
            en_q <= 1'b0;
            lock_s_q <= 2'h0;
        end else begin
            lock_s_q <= {lock_s_q[0], link.test_output_pin};
            pready_q <= acc;
            pslverr_q <= acc & ~mapped;
            if (acc & ~pwrite)
                prdata_q <= rd_mux;
            if (wr & hit_word & ~busy)
                word_q <= pwdata[`PSP_WORD_BITS-1:0];
            if (wr & hit_ctrl)
                en_q <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= PSP_IDLE;
            shreg_q <= '0;
            bits_q <= 5'h0;
            div_q <= 8'h0;
            sclk_q <= 1'b0;
            sdata_q <= 1'b0;
            strobe_q <= 1'b0;
        end else begin
            div_q <= (busy && !tick) ? div_q + 8'h1 : 8'h0;
            unique case (st_q)
                PSP_IDLE: begin
                    strobe_q <= go ? 1'b0 : strobe_q;
                    if (go) begin
                        shreg_q <= word_q;
                        sdata_q <= word_q[`PSP_WORD_BITS-1];
                        bits_q <= 5'h0;
                        st_q <= PSP_LOW;
                    end
                end
                PSP_LOW: if (tick) begin
                    sclk_q <= 1'b1;
                    st_q <= PSP_HIGH;
                end
                PSP_HIGH: if (tick) begin
                    sclk_q <= 1'b0;
                    if (bits_q == 5'(`PSP_WORD_BITS - 1)) begin
                        st_q <= PSP_END;
                    end else begin
                        shreg_q <= {shreg_q[`PSP_WORD_BITS-2:0], 1'b0};
                        sdata_q <= shreg_q[`PSP_WORD_BITS-2];
                        bits_q <= bits_q + 5'h1;
                        st_q <= PSP_LOW;
                    end
                end
                PSP_END: if (tick) begin
                    strobe_q <= 1'b1;
                    st_q <= PSP_IDLE;
                end
            endcase
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign link.sclk = sclk_q;
    assign link.sdata = sdata_q;
    assign link.latch_load_strobe = strobe_q;
    assign link.power_enable = en_q;
endmodule

// [verification/psp_link_monitor.sv]
// Checker for the host-driven link wires and the test output.
// Assumes all wires are registered in the pclk domain by their ends.
module psp_link_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic latch_load_strobe,
    input wire logic power_enable,
    input wire logic test_output_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] bits_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Counts serial clock rises since the strobe last fell
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            bits_q <= 6'h0;
        else if ($fell(latch_load_strobe))
            bits_q <= 6'h0;
        else if ($rose(sclk))
            bits_q <= bits_q + 6'h1;
    end
    chk_shift_in_frame: assert property (
        $rose(sclk) |-> !latch_load_strobe)
        else $error("serial clock rose while strobe high");
    chk_word_length: assert property (
        $rose(latch_load_strobe) |-> bits_q == 6'h18)
        else $error("strobe rose after a bit count other than 24");
    chk_high_phase: assert property ($rose(sclk) |-> sclk [*3])
        else $error("serial clock high phase too short");
    chk_low_phase: assert property ($fell(sclk) |-> !sclk [*3])
        else $error("serial clock low phase too short");
    chk_data_setup: assert property ($rose(sclk) |-> $stable(sdata))
        else $error("data changed at serial clock rise");
    chk_data_hold: assert property (
        sclk && $past(sclk) |-> $stable(sdata))
        else $error("data changed while serial clock high");
    chk_strobe_idle: assert property (
        $rose(latch_load_strobe) |-> !sclk)
        else $error("strobe rose with serial clock high");
    chk_test_off: assert property (
        !power_enable [*5] |-> !test_output_pin)
        else $error("test output active while disabled");
    cover property ($rose(power_enable) ##[1:8] test_output_pin);
endmodule

// [verification/testbench.sv]
// Bench: APB host end joined to the device end over the link interface.
// Assumes the host answers APB with pready and a 24-bit latch layout.
`include "psp_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, lock_status = 1'b1;
    logic [23:0] func_l, ref_l, ab_l;
    logic powered_down, counters_held, pump_tristate, reset_pulse;
    int error_cnt = 0;
    int n_checks = 0;
    int pulses = 0;
    psp_link_if link();
    psp_host i_psp_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    psp_device i_psp_device (.pclk(pclk), .presetn(presetn), .link(link),
        .func_latch(func_l), .ref_latch(ref_l), .ab_latch(ab_l),
        .powered_down(powered_down), .counters_held(counters_held),
        .pump_tristate(pump_tristate), .reset_pulse(reset_pulse),
        .lock_status(lock_status));
    psp_link_monitor i_psp_link_monitor (.pclk(pclk), .presetn(presetn),
        .sclk(link.sclk), .sdata(link.sdata),
        .latch_load_strobe(link.latch_load_strobe),
        .power_enable(link.power_enable),
        .test_output_pin(link.test_output_pin));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) if (reset_pulse === 1'b1) pulses++;
    task automatic summarize;
        $display("mismatches %0d, checks %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Complete only at an edge that samples pready high
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Waits on the busy flag, then lets the sync stages settle
    task automatic send(input logic [23:0] w);
        logic [31:0] q;
        logic e;
        apb(1'b1, `PSP_REG_WORD, {8'h00, w}, q, e);
        apb(1'b1, `PSP_REG_CMD, 32'h1, q, e);
        q = 32'h1;
        // A hang here is ended by the watchdog
        while (q[0] !== 1'b0)
            apb(1'b0, `PSP_REG_STAT, 32'h0, q, e);
        repeat (20) @(posedge pclk);
    endtask
    initial begin
        #500000;
        error_cnt++;
        summarize();
    end
    initial begin
        logic [31:0] q;
        logic e;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(func_l | ref_l | ab_l, 32'h0);
        check({powered_down, counters_held, pump_tristate}, 32'h7);
        check(reset_pulse, 32'h0);
        apb(1'b0, `PSP_REG_FUNC, 32'h0, q, e);
        check(q, 32'h0);
        check(e, 32'h1);
        // Init word first after supply, then the enable-gated loads
        send(24'h5a3c93);
        // Enable-gated start, all loads done while powered down
        send(24'h5a3c92);
        send(24'hc3a5f0);
        send(24'h36e9d1);
        check(pulses, 32'h2);
        check(func_l, 32'h5a3c92);
        check(ref_l, 32'hc3a5f0);
        check(ab_l, 32'h36e9d1);
        check(powered_down, 32'h1);
        check(link.test_output_pin, 32'h0);
        apb(1'b1, `PSP_REG_CTRL, 32'h1, q, e);
        repeat (`PSP_SETTLE_CYC) @(posedge pclk);
        check({powered_down, counters_held, pump_tristate}, 32'h0);
        check(link.test_output_pin, 32'h1);
        apb(1'b0, `PSP_REG_STAT, 32'h0, q, e);
        check(q[2:0], 32'h6);
        apb(1'b1, `PSP_REG_CTRL, 32'h0, q, e);
        repeat (10) @(posedge pclk);
        check(powered_down, 32'h1);
        apb(1'b1, `PSP_REG_CTRL, 32'h1, q, e);
        lock_status <= 1'b0;
        repeat (10) @(posedge pclk);
        check(ab_l, 32'h36e9d1);
        check(powered_down, 32'h0);
        apb(1'b0, `PSP_REG_STAT, 32'h0, q, e);
        check(q[2:0], 32'h2);
        // Counter-reset start
        send(24'h5a3c96);
        check({powered_down, counters_held, pump_tristate}, 32'h3);
        send(24'h0f0f0c);
        send(24'h1e1e1d);
        check(counters_held, 32'h1);
        send(24'h5a3c92);
        check({counters_held, pump_tristate}, 32'h0);
        check(ref_l, 32'h0f0f0c);
        // Init word, then first and second AB loads
        pulses = 0;
        send(24'h123453);
        check(func_l, 32'h123453);
        check(pulses, 32'h1);
        send(24'h0000f5);
        check(pulses, 32'h2);
        send(24'h800001);
        check(pulses, 32'h2);
        check(ab_l, 32'h800001);
        summarize();
    end
endmodule
